// ---- design/dsw_consts.vh ----
// constants for the dac serial write and error front end
`ifndef DSW_CONSTS_VH
`define DSW_CONSTS_VH

// command field codes, address in bits 7..3, command in 2..1, bit 0 reserved
`define DSW_CMD_WRITE      2'h0
`define DSW_CMD_DISABLE    2'h1
`define DSW_CMD_ENABLE     2'h2
`define DSW_CMD_READ       2'h3

// bit counts in serial clocks: command decode point, short and long frame lengths
`define DSW_BITS_ADDR_CMD  5'h07
`define DSW_BITS_SHORT     5'h08
`define DSW_BITS_LONG      5'h18

// address map: volatile and nonvolatile blocks
`define DSW_ADDR_DAC0      5'h00
`define DSW_ADDR_DAC4      5'h04
`define DSW_ADDR_VREF      5'h08
`define DSW_ADDR_PDOWN     5'h09
`define DSW_ADDR_GAIN      5'h0A
`define DSW_ADDR_NV_BASE   5'h10
`define DSW_ADDR_NV_LAST   5'h19

// address classes returned by the decoder
`define DSW_KIND_NONE      2'h0
`define DSW_KIND_VOL       2'h1
`define DSW_KIND_NV        2'h2

// reset values
`define DSW_RST_REG16      16'h0000
`define DSW_RST_ADDR       5'h00

// timing: clock rate and eeprom write cycle time
`define DSW_CLK_MHZ        100
`define DSW_EE_WRITE_US    10
`define DSW_EE_WRITE_CYC   (`DSW_EE_WRITE_US * `DSW_CLK_MHZ)

`endif

// ---- design/dsw_sync.v ----
// two flip-flop synchroniser for the serial and strobe pins
`timescale 1ns/10ps
module dsw_sync #(
	parameter WIDTH = 5,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input  wire             i_clk,
	input  wire             i_rst,
	input  wire [WIDTH-1:0] i_async,
	output reg  [WIDTH-1:0] o_sync
);

	reg [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta   <= RST_VAL;
			o_sync <= RST_VAL;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule

// ---- design/dsw_out_bank.v ----
// output register bank of the dac channels with registered read port
`timescale 1ns/10ps
module dsw_out_bank #(
	parameter DEPTH = 8,
	parameter AW    = 3,
	parameter WIDTH = 12
) (
	input  wire             i_clk,
	input  wire             i_rst,
	input  wire             i_wr_en,
	input  wire [AW-1:0]    i_wr_addr,
	input  wire [WIDTH-1:0] i_wr_data,
	input  wire [AW-1:0]    i_rd_addr,
	output reg  [WIDTH-1:0] o_rd_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	integer         k;

	// cleared at reset so the analog side starts from code zero
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (k = 0; k < DEPTH; k = k + 1) begin
				mem[k] <= {WIDTH{1'b0}};
			end
			o_rd_data <= {WIDTH{1'b0}};
		end else begin
			if (i_wr_en) begin
				mem[i_wr_addr] <= i_wr_data;
			end
			o_rd_data <= mem[i_rd_addr];
		end
	end

endmodule

// ---- design/dsw_spi_core.v ----
// serial command front end: command check, volatile writes, eeprom write start
`timescale 1ns/10ps
`include "dsw_consts.vh"
module dsw_spi_core #(
	parameter CHANNELS   = 8,
	parameter RES_BITS   = 12,
	parameter EE_CYCLES  = `DSW_EE_WRITE_CYC
) (
	input  wire                i_clk,
	input  wire                i_rst,
	input  wire                i_cs_n,
	input  wire                i_sck,
	input  wire                i_sdi,
	input  wire                i_lat_n,
	input  wire                i_hv_level,
	input  wire                i_lock_dac,
	input  wire                i_lock_cfg,
	input  wire [2:0]          i_out_sel,
	output reg                 o_sdo,
	output reg                 o_sdo_oe_n,
	output reg                 o_command_error_flag,
	output reg                 o_hv_mode,
	output reg  [15:0]         o_vref_ctrl,
	output reg  [15:0]         o_power_down_ctrl,
	output reg  [15:0]         o_gain_status,
	output wire [RES_BITS-1:0] o_out_value,
	output reg                 o_nv_wr_start,
	output reg  [4:0]          o_nv_wr_addr,
	output reg  [15:0]         o_nv_wr_data,
	output reg                 o_eeprom_write_active
);

	// timer is 16 bits wide; the load value is cut to that width on purpose
	localparam integer EE_LOAD_I = EE_CYCLES - 1;
	localparam [15:0]  EE_LOAD   = EE_LOAD_I[15:0];

	// synchronised pins: cs_n, sck, sdi, lat_n, hv
	wire [4:0]          pins_s;
	wire                cs_n_s;
	wire                sck_s;
	wire                sdi_s;
	wire                lat_n_s;
	wire                hv_s;
	reg                 cs_n_d;
	reg                 sck_d;
	wire                cs_fall;
	wire                cs_rise;
	wire                sck_rise;
	wire                sck_fall;

	// serial machine state
	reg                 frame_on;
	reg                 seen_rise;
	reg  [4:0]          bit_cnt;
	reg  [23:0]         shreg;
	reg                 err;
	reg                 ignore_cmd;
	reg                 is_write;
	reg                 is_nv;
	reg  [4:0]          addr_ptr;
	reg                 nv_pending;
	reg  [4:0]          nv_addr;
	reg  [15:0]         nv_data;

	// combinational helpers
	reg  [23:0]         next_shreg;
	reg  [4:0]          next_cnt;
	reg  [4:0]          cmd_addr;
	reg  [1:0]          cmd_code;
	reg  [1:0]          cmd_kind;
	reg                 cmd_bad;
	reg                 cmd_ign;

	// volatile dac registers and latch transfer
	reg  [RES_BITS-1:0] dac_vol [0:7];
	reg  [7:0]          pend;
	reg                 xfer_en;
	reg  [2:0]          xfer_idx;
	reg  [15:0]         ee_cnt;
	integer             k;
	integer             m;

	// classify an address as unimplemented, volatile or nonvolatile
	function [1:0] dsw_addr_kind;
		input [4:0] a;
		input       octal;
		reg   [4:0] off;
		begin
			off = a & 5'h0F;
			if (a > `DSW_ADDR_NV_LAST || (a > `DSW_ADDR_GAIN && a < `DSW_ADDR_NV_BASE)) begin
				dsw_addr_kind = `DSW_KIND_NONE;
			end else if (a == (`DSW_ADDR_NV_BASE | `DSW_ADDR_GAIN)) begin
				dsw_addr_kind = `DSW_KIND_NONE;
			end else if (!octal && off >= `DSW_ADDR_DAC4 && off < `DSW_ADDR_VREF) begin
				dsw_addr_kind = `DSW_KIND_NONE;
			end else if (a < `DSW_ADDR_NV_BASE) begin
				dsw_addr_kind = `DSW_KIND_VOL;
			end else begin
				dsw_addr_kind = `DSW_KIND_NV;
			end
		end
	endfunction

	// lock bits guard dac locations and configuration locations except gain
	function dsw_locked;
		input [4:0] a;
		input       lock_dac;
		input       lock_cfg;
		reg   [4:0] off;
		begin
			off = a & 5'h0F;
			if (off < `DSW_ADDR_VREF) begin
				dsw_locked = lock_dac;
			end else begin
				dsw_locked = lock_cfg && (off != `DSW_ADDR_GAIN);
			end
		end
	endfunction

	dsw_sync #(
		.WIDTH   (5),
		.RST_VAL (5'h1A) // idle levels: cs high, sck high, latch high
	) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async ({i_cs_n, i_sck, i_sdi, i_lat_n, i_hv_level}),
		.o_sync  (pins_s)
	);

	assign cs_n_s   = pins_s[4];
	assign sck_s    = pins_s[3];
	assign sdi_s    = pins_s[2];
	assign lat_n_s  = pins_s[1];
	assign hv_s     = pins_s[0];
	assign cs_fall  = cs_n_d & ~cs_n_s;
	assign cs_rise  = ~cs_n_d & cs_n_s;
	assign sck_rise = ~sck_d & sck_s & ~cs_n_s & frame_on;
	assign sck_fall = sck_d & ~sck_s & ~cs_n_s & frame_on;

	// edge history of the synchronised cs_n and sck pins
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cs_n_d <= 1'b1;
			sck_d  <= 1'b1; // matches the synchroniser reset, no false edge
		end else begin
			cs_n_d <= cs_n_s;
			sck_d  <= sck_s;
		end
	end

	// next shift value and decode of the first seven command bits
	always @* begin
		next_shreg = {shreg[22:0], sdi_s};
		next_cnt   = bit_cnt + 5'h01;
		cmd_addr   = next_shreg[6:2];
		cmd_code   = next_shreg[1:0];
		cmd_kind   = dsw_addr_kind(cmd_addr, CHANNELS == 8);
		cmd_bad    = 1'b0;
		cmd_ign    = 1'b0;
		if (cmd_kind == `DSW_KIND_NONE) begin
			cmd_bad = 1'b1;
		end
		if (nv_pending) begin
			cmd_bad = 1'b1;
		end
		if ((cmd_code == `DSW_CMD_ENABLE || cmd_code == `DSW_CMD_DISABLE) && !o_hv_mode) begin
			cmd_bad = 1'b1;
		end
		if (cmd_code == `DSW_CMD_WRITE && dsw_locked(cmd_addr, i_lock_dac, i_lock_cfg)) begin
			cmd_bad = 1'b1;
		end
		if (cmd_kind == `DSW_KIND_NV && o_eeprom_write_active) begin
			cmd_ign = 1'b1;
		end
		if (cmd_code != `DSW_CMD_WRITE) begin
			cmd_ign = 1'b1; // read and configuration bodies carry no action here
		end
	end

	// pick the lowest channel awaiting transfer to the output bank
	always @* begin
		xfer_en  = 1'b0;
		xfer_idx = 3'h0;
		for (k = 7; k >= 0; k = k - 1) begin
			if (pend[k] && k < CHANNELS) begin
				xfer_en  = ~lat_n_s;
				xfer_idx = k[2:0];
			end
		end
	end

	// serial machine: framing, command check, writes, output bit
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			frame_on             <= 1'b0;
			seen_rise            <= 1'b0;
			bit_cnt              <= 5'h00;
			shreg                <= 24'h000000;
			err                  <= 1'b0;
			ignore_cmd           <= 1'b0;
			is_write             <= 1'b0;
			is_nv                <= 1'b0;
			addr_ptr             <= `DSW_RST_ADDR;
			nv_pending           <= 1'b0;
			nv_addr              <= `DSW_RST_ADDR;
			nv_data              <= `DSW_RST_REG16;
			o_sdo                <= 1'b1;
			o_sdo_oe_n           <= 1'b1;
			o_command_error_flag <= 1'b1;
			o_hv_mode            <= 1'b0;
			o_vref_ctrl          <= `DSW_RST_REG16;
			o_power_down_ctrl    <= `DSW_RST_REG16;
			o_gain_status        <= `DSW_RST_REG16;
			o_nv_wr_start        <= 1'b0;
			o_nv_wr_addr         <= `DSW_RST_ADDR;
			o_nv_wr_data         <= `DSW_RST_REG16;
			pend                 <= 8'h00;
			for (m = 0; m < 8; m = m + 1) begin
				dac_vol[m] <= {RES_BITS{1'b0}};
			end
		end else begin
			o_nv_wr_start <= 1'b0;
			if (xfer_en) begin
				pend[xfer_idx] <= 1'b0;
			end
			if (cs_fall) begin
				// a new frame may follow a release at once
				frame_on             <= 1'b1;
				seen_rise            <= 1'b0;
				bit_cnt              <= 5'h00;
				err                  <= 1'b0;
				nv_pending           <= 1'b0;
				o_hv_mode            <= hv_s;
				o_sdo                <= 1'b1;
				o_sdo_oe_n           <= 1'b0;
				o_command_error_flag <= 1'b1;
			end else if (cs_rise) begin
				// eeprom cycle starts only on a whole, clean frame
				if (nv_pending && !err && bit_cnt == 5'h00) begin
					o_nv_wr_start <= 1'b1;
					o_nv_wr_addr  <= nv_addr;
					o_nv_wr_data  <= nv_data;
				end
				frame_on             <= 1'b0;
				err                  <= 1'b0;
				nv_pending           <= 1'b0;
				o_sdo_oe_n           <= 1'b1;
				o_sdo                <= 1'b1;
				o_command_error_flag <= 1'b1;
			end else if (sck_rise && !err) begin
				seen_rise <= 1'b1;
				shreg     <= next_shreg;
				bit_cnt   <= next_cnt;
				if (next_cnt == `DSW_BITS_ADDR_CMD) begin
					addr_ptr             <= cmd_addr;
					err                  <= cmd_bad;
					o_command_error_flag <= ~cmd_bad;
					ignore_cmd           <= cmd_ign;
					is_write             <= (cmd_code == `DSW_CMD_WRITE);
					is_nv                <= (cmd_kind == `DSW_KIND_NV);
					if (cmd_bad) begin
						nv_pending <= 1'b0;
					end
				end
				if (next_cnt == `DSW_BITS_SHORT && !is_write
					&& (shreg[0] ^ shreg[1])) begin
					bit_cnt <= 5'h00; // eight-clock commands end here
				end
				if (next_cnt == `DSW_BITS_LONG) begin
					bit_cnt <= 5'h00;
					if (is_write && !ignore_cmd && !is_nv) begin
						case (addr_ptr)
							`DSW_ADDR_VREF: begin
								o_vref_ctrl <= next_shreg[15:0];
							end
							`DSW_ADDR_PDOWN: begin
								o_power_down_ctrl <= next_shreg[15:0];
							end
							`DSW_ADDR_GAIN: begin
								o_gain_status <= next_shreg[15:0];
							end
							default: begin
								dac_vol[addr_ptr[2:0]] <= next_shreg[RES_BITS-1:0];
								pend[addr_ptr[2:0]]    <= 1'b1;
							end
						endcase
					end
					if (is_write && !ignore_cmd && is_nv) begin
						nv_pending <= 1'b1;
						nv_addr    <= addr_ptr;
						nv_data    <= next_shreg[15:0];
					end
				end
			end else if (sck_fall && seen_rise) begin
				// idle-high clocks give a fall before the first rise; skip it
				o_sdo <= ~err;
			end
		end
	end

	// eeprom write cycle timer, busy flag seen by the command check
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ee_cnt                <= 16'h0000;
			o_eeprom_write_active <= 1'b0;
		end else if (o_nv_wr_start) begin
			ee_cnt                <= EE_LOAD;
			o_eeprom_write_active <= 1'b1;
		end else if (ee_cnt != 16'h0000) begin
			ee_cnt <= ee_cnt - 16'h0001;
		end else begin
			o_eeprom_write_active <= 1'b0;
		end
	end

	dsw_out_bank #(
		.DEPTH     (8),
		.AW        (3),
		.WIDTH     (RES_BITS)
	) u_out_bank (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_wr_en   (xfer_en),
		.i_wr_addr (xfer_idx),
		.i_wr_data (dac_vol[xfer_idx]),
		.i_rd_addr (i_out_sel),
		.o_rd_data (o_out_value)
	);

endmodule

// ---- verification/dsw_spi_props.sv ----
// port assertions for the dac serial command front end
`timescale 1ns/10ps
module dsw_spi_props #(
	parameter RES_BITS = 12
) (
	input wire                i_clk,
	input wire                i_rst,
	input wire                i_cs_n,
	input wire                i_sck,
	input wire                i_lat_n,
	input wire                i_hv_level,
	input wire [2:0]          i_out_sel,
	input wire                o_sdo,
	input wire                o_sdo_oe_n,
	input wire                o_command_error_flag,
	input wire                o_hv_mode,
	input wire [RES_BITS-1:0] o_out_value,
	input wire                o_nv_wr_start,
	input wire                o_eeprom_write_active
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// windows allow for the two-stage pin synchronisers
	cs_release_idle_a: assert property ($rose(i_cs_n) |-> ##[1:5] o_sdo_oe_n)
		else $error("serial output still driven after deselect");
	frame_drive_a: assert property ($fell(i_cs_n) |-> ##[2:4] (!o_sdo_oe_n && o_sdo))
		else $error("serial output not driven high at frame start");
	flag_clear_a: assert property (i_cs_n [*6] |-> o_command_error_flag)
		else $error("error flag not cleared by deselect");
	err_sdo_low_a: assert property ($fell(i_sck) && !i_cs_n && !o_command_error_flag
		|-> ##[2:4] (!o_sdo || o_sdo_oe_n))
		else $error("serial output high while in error");
	ok_sdo_high_a: assert property ($fell(i_sck) && !i_cs_n && o_command_error_flag
		|-> ##[2:4] (o_sdo || o_sdo_oe_n))
		else $error("serial output low while command valid");
	nv_start_idle_a: assert property (o_nv_wr_start |-> !o_eeprom_write_active)
		else $error("eeprom write started during a write cycle");
	nv_active_a: assert property (o_nv_wr_start |=> o_eeprom_write_active [*8])
		else $error("write cycle not active after start");
	hv_capture_a: assert property ($fell(i_cs_n) |-> ##[2:4] (o_hv_mode == i_hv_level))
		else $error("high voltage mode not captured");
	// latch high long enough means nothing may reach the output register
	latch_hold_a: assert property (i_lat_n [*8] ##1 $stable(i_out_sel) [*2]
		|-> $stable(o_out_value))
		else $error("output changed while latch high");
endmodule
bind dsw_spi_core dsw_spi_props #(.RES_BITS(RES_BITS)) dsw_spi_props_inst (.i_clk, .i_rst,
	.i_cs_n, .i_sck, .i_lat_n, .i_hv_level, .i_out_sel, .o_sdo, .o_sdo_oe_n,
	.o_command_error_flag, .o_hv_mode, .o_out_value, .o_nv_wr_start, .o_eeprom_write_active);

// ---- verification/dsw_host.sv ----
// spi host model driving the serial pins of the dac front end
`timescale 1ns/10ps
module dsw_host (
	input  wire i_clk,
	output reg  o_cs_n,
	output reg  o_sck,
	output reg  o_sdi
);
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b1;
		o_sdi = 1'b0;
	end
	// sends n bits msb first, 80 ns per bit; sck idles high and stands still between frames
	task frame(input [47:0] w, input integer n, input integer gap, input integer keep);
		integer i;
		begin
			o_cs_n = 1'b0;
			repeat (4) @(negedge i_clk);
			for (i = n - 1; i >= 0; i = i - 1) begin
				o_sck = 1'b0;
				o_sdi = w[i];
				repeat (4) @(negedge i_clk);
				o_sck = 1'b1;
				repeat (4) @(negedge i_clk);
			end
			if (keep == 0) begin
				o_cs_n = 1'b1;
				o_sdi = ~o_sdi; // released line must not keep a stale bit
				repeat (gap) @(negedge i_clk);
			end
		end
	endtask
endmodule

// ---- verification/dsw_spi_core_test.sv ----
// self-checking bench of the dac serial command front end
`timescale 1ns/10ps
module dsw_spi_core_test;
	reg         i_clk, i_rst, i_lat_n, i_hv_level, i_lock_dac, i_lock_cfg;
	reg  [2:0]  i_out_sel;
	wire        i_cs_n, i_sck, i_sdi, o_command_error_flag, o_hv_mode;
	wire        o_nv_wr_start, o_eeprom_write_active;
	wire [15:0] o_vref_ctrl, o_power_down_ctrl, o_gain_status, o_nv_wr_data;
	wire [11:0] o_out_value;
	wire [4:0]  o_nv_wr_addr;
	integer     failures, n_compared, t;
	integer     starts = 0;

	dsw_spi_core #(.CHANNELS(8), .RES_BITS(12), .EE_CYCLES(600)) dsw_spi_core_inst (
		.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_sdi(i_sdi),
		.i_lat_n(i_lat_n), .i_hv_level(i_hv_level), .i_lock_dac(i_lock_dac),
		.i_lock_cfg(i_lock_cfg), .i_out_sel(i_out_sel), .o_sdo(), .o_sdo_oe_n(),
		.o_command_error_flag(o_command_error_flag), .o_hv_mode(o_hv_mode),
		.o_vref_ctrl(o_vref_ctrl), .o_power_down_ctrl(o_power_down_ctrl),
		.o_gain_status(o_gain_status), .o_out_value(o_out_value),
		.o_nv_wr_start(o_nv_wr_start), .o_nv_wr_addr(o_nv_wr_addr),
		.o_nv_wr_data(o_nv_wr_data), .o_eeprom_write_active(o_eeprom_write_active));
	dsw_host dsw_host_inst (.i_clk(i_clk), .o_cs_n(i_cs_n), .o_sck(i_sck), .o_sdi(i_sdi));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// counts eeprom start pulses, which last one cycle only
	always @(posedge i_clk) if (o_nv_wr_start === 1'b1) starts <= starts + 1;

	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task summarize;
		begin
			$display("compared %0d mismatches %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// hang guard
	initial begin
		#400000;
		failures = failures + 1;
		summarize;
	end

	initial begin
		failures = 0;
		n_compared = 0;
		{i_rst, i_lat_n, i_hv_level, i_lock_dac, i_lock_cfg} = 5'h18;
		i_out_sel = 3'h5;
		repeat (8) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (6) @(negedge i_clk);
		chk(o_vref_ctrl, 16'h0000);
		// flag looked at while the frame is still selected; release forces it high
		dsw_host_inst.frame({8'h40, 16'h1234}, 24, 0, 1);
		chk(o_vref_ctrl, 16'h1234);
		chk(o_command_error_flag, 16'h0001);
		dsw_host_inst.frame(0, 0, 6, 0);
		dsw_host_inst.frame({8'h48, 16'hABCD, 8'h50, 16'h5A5A}, 48, 6, 0);
		chk(o_power_down_ctrl, 16'hABCD);
		chk(o_gain_status, 16'h5A5A);
		dsw_host_inst.frame({8'h28, 16'hF321}, 24, 6, 0);
		chk(o_out_value, 16'h0000);
		i_lat_n = 1'b0;
		repeat (8) @(negedge i_clk);
		chk(o_out_value, 16'h0321);
		i_lat_n = 1'b1;
		// cut frames: 16 and 23 clocks
		dsw_host_inst.frame({8'h40, 8'h0F}, 16, 6, 0);
		chk(o_vref_ctrl, 16'h1234);
		dsw_host_inst.frame(24'h400F0F >> 1, 23, 6, 0);
		chk(o_vref_ctrl, 16'h1234);
		dsw_host_inst.frame({8'h58, 16'h0001, 8'h40, 16'h0002}, 48, 0, 1);
		chk(o_command_error_flag, 16'h0000);
		dsw_host_inst.frame(0, 0, 6, 0);
		chk(o_command_error_flag, 16'h0001);
		chk(o_vref_ctrl, 16'h1234);
		i_lock_dac = 1'b1;
		dsw_host_inst.frame({8'h00, 16'h0055}, 24, 0, 1);
		chk(o_command_error_flag, 16'h0000);
		dsw_host_inst.frame(0, 0, 6, 0);
		i_lock_dac = 1'b0;
		dsw_host_inst.frame(8'h84, 8, 0, 1);
		chk(o_command_error_flag, 16'h0000);
		dsw_host_inst.frame(0, 0, 6, 0);
		i_hv_level = 1'b1;
		dsw_host_inst.frame(8'h84, 8, 0, 1);
		chk(o_command_error_flag, 16'h0001);
		chk(o_hv_mode, 16'h0001);
		dsw_host_inst.frame(0, 0, 6, 0);
		i_hv_level = 1'b0;
		// nonvolatile write, then reselect at once while the cycle runs
		dsw_host_inst.frame({8'h80, 16'h0777}, 24, 1, 0);
		dsw_host_inst.frame({8'h40, 16'h00AA}, 24, 6, 0);
		chk(starts[15:0], 16'h0001);
		chk({11'h000, o_nv_wr_addr}, 16'h0010);
		chk(o_nv_wr_data, 16'h0777);
		chk(o_vref_ctrl, 16'h00AA);
		dsw_host_inst.frame({8'h88, 16'h0123}, 24, 0, 1);
		chk(o_command_error_flag, 16'h0001);
		dsw_host_inst.frame(0, 0, 6, 0);
		chk(starts[15:0], 16'h0001);
		t = 0;
		while (o_eeprom_write_active !== 1'b0 && t < 1000) begin
			@(negedge i_clk);
			t = t + 1;
		end
		// a stuck write cycle counts once and the run goes on to the report
		if (t == 1000) begin
			failures = failures + 1;
		end
		dsw_host_inst.frame({8'h80, 16'h0001, 8'h88, 16'h0002}, 48, 0, 1);
		chk(o_command_error_flag, 16'h0000);
		dsw_host_inst.frame(0, 0, 6, 0);
		chk(starts[15:0], 16'h0001);
		// whole nonvolatile write plus one stray clock: count not a multiple of eight
		dsw_host_inst.frame({8'h80, 16'h0003, 1'b1}, 25, 6, 0);
		chk(starts[15:0], 16'h0001);
		summarize;
	end
endmodule
